// ===== hw/ahrt_pkg.sv
/*
 * Constants shared by the acknowledge handler and its testbench:
 * attribute and service codes, status codes, defaults and timebase.
 * Assumes a single 125 MHz node clock.
 */
`default_nettype none

package ahrt_pkg;

	// ---------------------------------------------------------------
	// attribute identifiers
	// ---------------------------------------------------------------
	localparam logic [7:0] CLS_ATTR_REVISION  = 8'h01;
	localparam logic [7:0] CLS_ATTR_MAX_INST  = 8'h02;
	localparam logic [7:0] ATTR_WAIT_TIME     = 8'h01;
	localparam logic [7:0] ATTR_RETRY_LIMIT   = 8'h02;
	localparam logic [7:0] ATTR_PROD_REF      = 8'h03;
	localparam logic [7:0] ATTR_ACK_LIST_CAP  = 8'h04;
	localparam logic [7:0] ATTR_ACK_LIST      = 8'h05;
	localparam logic [7:0] ATTR_DPATH_CAP     = 8'h06;

	// ---------------------------------------------------------------
	// service codes
	// ---------------------------------------------------------------
	localparam logic [7:0] SVC_GET_SINGLE     = 8'h0e;
	localparam logic [7:0] SVC_SET_SINGLE     = 8'h10;
	localparam logic [7:0] SVC_ADD_DPATH      = 8'h4b;
	localparam logic [7:0] SVC_REMOVE_DPATH   = 8'h4c;

	// ---------------------------------------------------------------
	// response status codes
	// ---------------------------------------------------------------
	localparam logic [7:0] ST_SUCCESS         = 8'h00;
	localparam logic [7:0] ST_SVC_UNSUPPORTED = 8'h08;
	localparam logic [7:0] ST_INVALID_VALUE   = 8'h09;
	localparam logic [7:0] ST_STATE_CONFLICT  = 8'h0c;
	localparam logic [7:0] ST_NOT_SETTABLE    = 8'h0e;
	localparam logic [7:0] ST_ATTR_UNSUPPORTED = 8'h14;

	// ---------------------------------------------------------------
	// reset and instantiation values
	// ---------------------------------------------------------------
	localparam logic [15:0] REVISION_VAL      = 16'h0001;
	localparam logic [15:0] WAIT_TIME_RST     = 16'h0010;
	localparam logic [7:0]  RETRY_LIMIT_RST   = 8'h01;
	localparam logic [15:0] PROD_REF_RST      = 16'h0000;

	// ---------------------------------------------------------------
	// timebase
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 8;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// connection state reported by the connection logic
	typedef enum logic [1:0] {
		CONN_NONEXISTENT,
		CONN_CONFIGURING,
		CONN_ESTABLISHED,
		CONN_TIMED_OUT
	} ahrt_conn_state_t;

endpackage : ahrt_pkg

`default_nettype wire

// ===== hw/ahrt_id_table.sv
/*
 * Small table of connection instance ids for the acknowledge list.
 * Registered read port, parallel compare against one id, and a
 * combinational view of one further slot for compaction moves.
 * Assumes a single clock; no reset is needed on the storage.
 */
`default_nettype none

module ahrt_id_table #(
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	input  wire logic             clk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [15:0]      wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [15:0]      rd_data,
	input  wire logic [15:0]      cmp_id,
	output logic      [DEPTH-1:0] hit_vec,
	input  wire logic [AW-1:0]    peek_addr,
	output logic      [15:0]      peek_data
);

	logic [15:0] mem_r [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
		rd_data <= mem_r[rd_addr];
	end

	// every slot is compared so an acknowledge is matched in one cycle
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			hit_vec[i] = (mem_r[i] == cmp_id);
		end
	end

	assign peek_data = mem_r[peek_addr];

endmodule : ahrt_id_table

`default_nettype wire

// ===== hw/ahrt_ack_handler.sv
/*
 * Acknowledge handler with retry timer for an acknowledged producer.
 * Holds wait time, retry limit, producing reference and the list of
 * connections receiving acknowledges; raises event pulses toward the
 * producing application. Attribute access answers two cycles after a
 * request. Assumes all inputs synchronous to clk and the connection
 * logic reporting every state change of an associated connection.
 */
`default_nettype none

module ahrt_ack_handler
	import ahrt_pkg::*;
#(
	parameter int MAX_MEMBERS   = 4,
	parameter int AW            = 2,
	parameter int DPATH_CAP     = 1,
	parameter int INSTANCE_NUM  = 1,
	parameter int TIMER_RES_MS  = 1,
	parameter int TICK_CYC      = TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        req_valid,
	input  wire logic        req_is_class,
	input  wire logic [7:0]  req_service,
	input  wire logic [7:0]  req_attr,
	input  wire logic [15:0] req_wdata,
	input  wire logic [7:0]  req_index,
	output logic             rsp_valid,
	output logic      [7:0]  rsp_status,
	output logic      [15:0] rsp_data,
	input  wire logic        conn_evt_valid,
	input  wire logic [15:0] conn_evt_id,
	input  wire logic [1:0]  conn_evt_state,
	input  wire logic        ack_rx_valid,
	input  wire logic [15:0] ack_rx_id,
	input  wire logic        ack_rx_has_data,
	input  wire logic        prod_data_sent,
	input  wire logic        prod_data_resent,
	output logic             ack_received_evt,
	output logic             ack_timeout_evt,
	output logic             retry_exhausted_event,
	output logic             ack_data_fwd,
	output logic      [7:0]  ack_data_fwd_path_len,
	output logic             active,
	output logic      [15:0] notify_conn_ref
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] round_up(input logic [15:0] v);
		logic [16:0] res;
		logic [16:0] r;
		res = 17'(TIMER_RES_MS);
		r = {1'b0, v} + res - 17'h1;
		r = r - (r % res);
		// saturate to the largest multiple that still fits
		if (r > 17'h0ffff) begin
			r = r - res;
		end
		round_up = r[15:0];
	endfunction : round_up

	function automatic logic [AW:0] first_set(
		input logic [MAX_MEMBERS-1:0] v);
		first_set = (AW+1)'(MAX_MEMBERS);
		for (int i = MAX_MEMBERS - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = (AW+1)'(i);
			end
		end
	endfunction : first_set

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0]            wait_r;
	logic [7:0]             retry_lim_r;
	logic [7:0]             retry_cnt_r;
	logic [15:0]            prod_ref_r;
	logic [AW:0]            count_r;
	logic [MAX_MEMBERS-1:0] pend_r;
	logic [16:0]            div_r;
	logic [15:0]            ms_left_r;
	logic                   run_r;
	logic [15:0]            dpath_conn_r;
	logic [7:0]             dpath_len_r;
	logic                   dpath_vld_r;
	logic                   s1_vld_r;
	logic [7:0]             s1_status_r;
	logic [15:0]            s1_data_r;
	logic                   s1_list_r;
	logic                   s1_cnt_r;

	// ---------------------------------------------------------------
	// request decode
	// ---------------------------------------------------------------
	wire is_get  = req_service == SVC_GET_SINGLE;
	wire is_set  = req_service == SVC_SET_SINGLE;
	wire inst_rq = req_valid && !req_is_class;
	wire wr_wait = inst_rq && is_set && req_attr == ATTR_WAIT_TIME;
	wire wr_lim  = inst_rq && is_set && req_attr == ATTR_RETRY_LIMIT;
	wire wr_ref  = inst_rq && is_set && req_attr == ATTR_PROD_REF;
	wire is_act  = count_r != '0;
	wire wait_ok = wr_wait && req_wdata != 16'h0000;
	wire ref_ok  = wr_ref && !is_act;
	wire add_dp  = inst_rq && req_service == SVC_ADD_DPATH;
	wire rem_dp  = inst_rq && req_service == SVC_REMOVE_DPATH
		&& dpath_vld_r && dpath_conn_r == req_wdata;
	wire [15:0] wait_rnd = round_up(req_wdata);
	wire rd_list = inst_rq && is_get && req_attr == ATTR_ACK_LIST;
	wire list_cnt = req_index == 8'h00;
	wire [AW-1:0] list_slot = AW'(req_index - 8'h01);

	logic [7:0]  dec_status;
	logic [15:0] dec_data;

	always_comb begin
		dec_status = ST_SUCCESS;
		dec_data   = 16'h0000;
		if (req_is_class) begin
			if (!is_get) begin
				dec_status = ST_SVC_UNSUPPORTED;
			end else if (req_attr == CLS_ATTR_REVISION) begin
				dec_data = REVISION_VAL;
			end else if (req_attr == CLS_ATTR_MAX_INST) begin
				dec_data = 16'(INSTANCE_NUM);
			end else begin
				dec_status = ST_ATTR_UNSUPPORTED;
			end
		end else if (add_dp) begin
			dec_status = DPATH_CAP == 0 || !dpath_vld_r
				|| dpath_conn_r == req_wdata
				? ST_SUCCESS : ST_STATE_CONFLICT;
		end else if (req_service == SVC_REMOVE_DPATH) begin
			dec_status = rem_dp ? ST_SUCCESS : ST_INVALID_VALUE;
		end else if (!is_get && !is_set) begin
			dec_status = ST_SVC_UNSUPPORTED;
		end else begin
			case (req_attr)
			ATTR_WAIT_TIME: begin
				if (is_set && !wait_ok) begin
					dec_status = ST_INVALID_VALUE;
				end
				dec_data = is_set && wait_ok ? wait_rnd
					: wait_r;
			end
			ATTR_RETRY_LIMIT: begin
				dec_data = {8'h00, is_set ? req_wdata[7:0]
					: retry_lim_r};
			end
			ATTR_PROD_REF: begin
				if (is_set && !ref_ok) begin
					dec_status = ST_STATE_CONFLICT;
				end
				dec_data = prod_ref_r;
			end
			ATTR_ACK_LIST_CAP, ATTR_ACK_LIST, ATTR_DPATH_CAP: begin
				if (is_set) begin
					dec_status = ST_NOT_SETTABLE;
				end
				if (req_attr == ATTR_ACK_LIST_CAP) begin
					dec_data = 16'(MAX_MEMBERS);
				end else if (req_attr == ATTR_DPATH_CAP) begin
					dec_data = 16'(DPATH_CAP);
				end else if (req_index > 8'(count_r)) begin
					dec_status = ST_INVALID_VALUE;
				end
			end
			default: begin
				dec_status = ST_ATTR_UNSUPPORTED;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// acknowledge list maintenance
	// ---------------------------------------------------------------
	logic [MAX_MEMBERS-1:0] hit_vec;
	logic [15:0]            tbl_rd;
	logic [15:0]            tail_id;
	logic [MAX_MEMBERS-1:0] live;
	logic [MAX_MEMBERS-1:0] conn_hit;
	logic [MAX_MEMBERS-1:0] ack_hit;

	always_comb begin
		for (int i = 0; i < MAX_MEMBERS; i++) begin
			live[i] = (AW+1)'(i) < count_r;
		end
	end

	// the compare port is shared: connection changes take precedence
	wire [15:0] cmp_id = conn_evt_valid ? conn_evt_id : ack_rx_id;
	assign conn_hit = hit_vec & live & {MAX_MEMBERS{conn_evt_valid}};
	assign ack_hit  = hit_vec & live
		& {MAX_MEMBERS{ack_rx_valid && !conn_evt_valid}};

	wire          est     = conn_state_is(CONN_ESTABLISHED);
	wire [AW:0]   hit_idx = first_set(conn_hit);
	wire          add_m   = est && conn_hit == '0
		&& count_r != (AW+1)'(MAX_MEMBERS);
	wire          rem_m   = conn_evt_valid && !est && conn_hit != '0;
	wire [AW-1:0] tail    = AW'(count_r - (AW+1)'(1));
	// removal moves the tail into the hole to keep the list packed
	wire          tbl_we  = add_m || (rem_m && hit_idx[AW-1:0] != tail);
	wire [AW-1:0] tbl_wa  = add_m ? AW'(count_r) : hit_idx[AW-1:0];
	wire [15:0]   tbl_wd  = add_m ? conn_evt_id : tail_id;

	function automatic logic conn_state_is(input ahrt_conn_state_t s);
		conn_state_is = conn_evt_valid && conn_evt_state == s;
	endfunction : conn_state_is

	ahrt_id_table #(
		.DEPTH (MAX_MEMBERS),
		.AW    (AW)
	) u_ids (
		.clk       (clk),
		.wr_en     (tbl_we),
		.wr_addr   (tbl_wa),
		.wr_data   (tbl_wd),
		.rd_addr   (list_slot),
		.rd_data   (tbl_rd),
		.cmp_id    (cmp_id),
		.hit_vec   (hit_vec),
		.peek_addr (tail),
		.peek_data (tail_id)
	);

	// ---------------------------------------------------------------
	// acknowledge tracking and retry timer
	// ---------------------------------------------------------------
	wire restart  = (prod_data_sent || prod_data_resent) && is_act;
	wire tick     = div_r == 17'(TICK_CYC - 1);
	wire ack_new  = (ack_hit & pend_r) != '0;
	logic [MAX_MEMBERS-1:0] pend_nxt;

	always_comb begin
		pend_nxt = pend_r & ~ack_hit;
		if (restart) begin
			pend_nxt = live;
		end
		if (rem_m) begin
			pend_nxt[hit_idx[AW-1:0]] = pend_nxt[tail];
			pend_nxt[tail] = 1'b0;
		end
	end

	wire all_acked = pend_nxt == '0;
	wire expire    = run_r && tick && ms_left_r == 16'h0001
		&& !restart && !all_acked;
	wire [7:0] cnt_inc = retry_cnt_r == 8'hff ? retry_cnt_r
		: retry_cnt_r + 8'h01;
	wire exhaust  = expire && cnt_inc >= retry_lim_r;

	always_ff @(posedge clk) begin
		if (sys_rst || restart) begin
			div_r <= '0;
		end else begin
			div_r <= tick ? 17'h0 : div_r + 17'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_r     <= 1'b0;
			ms_left_r <= WAIT_TIME_RST;
		end else if (restart) begin
			run_r     <= 1'b1;
			ms_left_r <= wait_r;
		end else if (all_acked || expire) begin
			run_r     <= 1'b0;
		end else if (run_r && tick) begin
			ms_left_r <= ms_left_r - 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_r  <= '0;
			count_r <= '0;
		end else begin
			pend_r  <= pend_nxt;
			count_r <= count_r + (AW+1)'(add_m)
				- (AW+1)'(rem_m);
		end
	end

	// ---------------------------------------------------------------
	// attribute registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_r      <= WAIT_TIME_RST;
			retry_lim_r <= RETRY_LIMIT_RST;
			prod_ref_r  <= PROD_REF_RST;
		end else begin
			if (wait_ok) begin
				wait_r <= wait_rnd;
			end
			if (wr_lim) begin
				retry_lim_r <= req_wdata[7:0];
			end
			if (ref_ok) begin
				prod_ref_r <= req_wdata;
			end
		end
	end

	// a limit write wins over a timeout in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst || wr_lim) begin
			retry_cnt_r <= 8'h00;
		end else if (expire) begin
			retry_cnt_r <= cnt_inc;
		end else if (restart && prod_data_sent) begin
			retry_cnt_r <= 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dpath_vld_r  <= 1'b0;
			dpath_conn_r <= 16'h0000;
			dpath_len_r  <= 8'h00;
		end else if (add_dp && dec_status == ST_SUCCESS
			&& DPATH_CAP != 0) begin
			dpath_vld_r  <= 1'b1;
			dpath_conn_r <= req_wdata;
			dpath_len_r  <= req_index;
		end else if (rem_dp) begin
			dpath_vld_r  <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	wire fwd = ack_new && ack_rx_has_data && dpath_vld_r
		&& dpath_conn_r == ack_rx_id;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_received_evt      <= 1'b0;
			ack_timeout_evt       <= 1'b0;
			retry_exhausted_event <= 1'b0;
			ack_data_fwd          <= 1'b0;
			ack_data_fwd_path_len <= 8'h00;
			active                <= 1'b0;
			notify_conn_ref       <= PROD_REF_RST;
		end else begin
			ack_received_evt      <= ack_new;
			ack_timeout_evt       <= expire;
			retry_exhausted_event <= exhaust;
			ack_data_fwd          <= fwd;
			ack_data_fwd_path_len <= dpath_len_r;
			active                <= (count_r + (AW+1)'(add_m)
				- (AW+1)'(rem_m)) != '0;
			notify_conn_ref       <= ref_ok ? req_wdata : prod_ref_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_vld_r    <= 1'b0;
			s1_status_r <= ST_SUCCESS;
			s1_data_r   <= 16'h0000;
			s1_list_r   <= 1'b0;
			s1_cnt_r    <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_status  <= ST_SUCCESS;
			rsp_data    <= 16'h0000;
		end else begin
			s1_vld_r    <= req_valid;
			s1_status_r <= dec_status;
			s1_data_r   <= rd_list && list_cnt
				? 16'(count_r) : dec_data;
			s1_list_r   <= rd_list && !list_cnt
				&& dec_status == ST_SUCCESS;
			s1_cnt_r    <= rd_list && list_cnt;
			rsp_valid   <= s1_vld_r;
			rsp_status  <= s1_status_r;
			rsp_data    <= s1_list_r ? tbl_rd : s1_data_r;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_zero_wait_write;
		wr_wait && req_wdata == 16'h0000;
	endsequence
	sequence s_reject_answer;
		##2 rsp_valid && rsp_status == ST_INVALID_VALUE;
	endsequence

	a_zero_wait_rejected: assert property (@(posedge clk)
		disable iff (sys_rst) s_zero_wait_write |-> s_reject_answer)
		else $error("zero wait time not rejected");
	a_wait_kept_valid: assert property (@(posedge clk)
		disable iff (sys_rst) s_zero_wait_write |=> $stable(wait_r))
		else $error("wait time changed on zero write");
	a_wait_rounded: assert property (@(posedge clk)
		disable iff (sys_rst) wait_ok |=>
		wait_r % 16'(TIMER_RES_MS) == 16'h0 && wait_r != 16'h0)
		else $error("stored wait time not a timer multiple");
	a_wait_echoed: assert property (@(posedge clk)
		disable iff (sys_rst) wait_ok |=> ##1
		rsp_valid && rsp_data == $past(wait_r))
		else $error("write response lacks loaded wait time");
	a_retry_cleared: assert property (@(posedge clk)
		disable iff (sys_rst) wr_lim |=> retry_cnt_r == 8'h00)
		else $error("retry counter not cleared");
	a_ref_locked: assert property (@(posedge clk)
		disable iff (sys_rst) wr_ref && is_act |=>
		$stable(prod_ref_r) ##1 rsp_status == ST_STATE_CONFLICT)
		else $error("reference written while active");
	a_revision_one: assert property (@(posedge clk)
		disable iff (sys_rst) req_valid && req_is_class && is_get
		&& req_attr == CLS_ATTR_REVISION |-> ##2 rsp_data == 16'h0001)
		else $error("class revision not one");
	a_timeout_counts: assert property (@(posedge clk)
		disable iff (sys_rst) expire && !wr_lim
		&& retry_cnt_r != 8'hff |=>
		ack_timeout_evt && retry_cnt_r == $past(retry_cnt_r) + 8'h01)
		else $error("timeout did not advance retry count");
	a_exhaust_at_limit: assert property (@(posedge clk)
		disable iff (sys_rst) retry_exhausted_event |->
		ack_timeout_evt && $past(cnt_inc) >= $past(retry_lim_r))
		else $error("retry exhausted before limit reached");
	a_timer_restart: assert property (@(posedge clk)
		disable iff (sys_rst) restart |=> run_r
		&& ms_left_r == $past(wait_r))
		else $error("wait timer not restarted");

endmodule : ahrt_ack_handler

`default_nettype wire

// ===== tb/ahrt_prod_app_model.sv
/*
 * Behavioural producing application facing the acknowledge handler.
 * Assumes clk and sys_rst shared with the handler; commands from bench.
 */
`default_nettype none

module ahrt_prod_app_model (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic send_req,
	input  wire logic resend_req,
	input  wire logic ack_timeout_evt,
	input  wire logic retry_exhausted_event,
	output var  logic prod_data_sent,
	output var  logic prod_data_resent
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// production and resend on timeout
	// ---------------------------------------------------------------
	// resends on timeout only while the limit is not reached, as a real producer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prod_data_sent   <= 1'b0;
			prod_data_resent <= 1'b0;
		end else begin
			prod_data_sent   <= send_req;
			prod_data_resent <= resend_req
				| (ack_timeout_evt & ~retry_exhausted_event);
		end
	end

endmodule : ahrt_prod_app_model

`default_nettype wire

// ===== tb/ahrt_ack_handler_tb.sv
/*
 * Self-checking bench for the acknowledge handler.
 * Assumes a 10-cycle tick and 4 ms timer resolution for short runs.
 */
`default_nettype none

module ahrt_ack_handler_tb
	import ahrt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TCK = 10;
	logic        clk = 0, sys_rst = 1, req_valid = 0, req_is_class = 0;
	logic [7:0]  req_service = 0, req_attr = 0, req_index = 0;
	logic [15:0] req_wdata = 0, conn_evt_id = 0, ack_rx_id = 0;
	logic [1:0]  conn_evt_state = 0;
	logic        conn_evt_valid = 0, ack_rx_valid = 0;
	logic        send_req = 0, resend_req = 0;
	logic        rsp_valid, ack_received_evt, ack_timeout_evt;
	logic        retry_exhausted_event, active, sent, resent;
	logic [7:0]  rsp_status, fwd_len;
	logic        ack_rx_has_data = 0, fwd;
	logic [15:0] rsp_data, notify_conn_ref;
	int          n_errors = 0, cmp_count = 0, n;
	logic        exh;

	always #4 clk = ~clk;

	ahrt_ack_handler #(.TIMER_RES_MS(4), .TICK_CYC(TCK)) dut (
		.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_is_class(req_is_class), .req_service(req_service),
		.req_attr(req_attr), .req_wdata(req_wdata), .req_index(req_index),
		.rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_data(rsp_data),
		.conn_evt_valid(conn_evt_valid), .conn_evt_id(conn_evt_id),
		.conn_evt_state(conn_evt_state), .ack_rx_valid(ack_rx_valid),
		.ack_rx_id(ack_rx_id), .ack_rx_has_data(ack_rx_has_data),
		.prod_data_sent(sent), .prod_data_resent(resent),
		.ack_received_evt(ack_received_evt),
		.ack_timeout_evt(ack_timeout_evt),
		.retry_exhausted_event(retry_exhausted_event),
		.ack_data_fwd(fwd), .ack_data_fwd_path_len(fwd_len), .active(active),
		.notify_conn_ref(notify_conn_ref));

	ahrt_prod_app_model app (.clk(clk), .sys_rst(sys_rst),
		.send_req(send_req), .resend_req(resend_req),
		.ack_timeout_evt(ack_timeout_evt),
		.retry_exhausted_event(retry_exhausted_event),
		.prod_data_sent(sent), .prod_data_resent(resent));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	// answer stands for one cycle after the edge that follows the taking edge
	task automatic req(input logic cls, input logic [7:0] svc, attr, idx,
		input logic [15:0] wd, input logic [7:0] st, input logic [15:0] exp,
		input bit cd);
		@(posedge clk);
		{req_valid, req_is_class, req_service} <= {1'b1, cls, svc};
		{req_attr, req_index, req_wdata} <= {attr, idx, wd};
		@(posedge clk);
		req_valid <= 1'b0;
		@(posedge clk);
		#1;
		chk(rsp_valid, 1'b1);
		chk(rsp_status, st);
		if (cd)
			chk(rsp_data, exp);
	endtask : req

	task automatic conn(input logic [15:0] id, input logic [1:0] st);
		@(posedge clk);
		{conn_evt_valid, conn_evt_id, conn_evt_state} <= {1'b1, id, st};
		@(posedge clk);
		conn_evt_valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask : conn

	// cycles until a timeout pulse, bounded
	task automatic wait_to;
		n = 0;
		while (ack_timeout_evt !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 400) begin
				n_errors++;
				$display("[FAIL] %0t no timeout seen", $time);
				final_report();
			end
		end
		exh = retry_exhausted_event;
	endtask : wait_to

	// one-cycle strobe: 2 send, 1 resend, 0 acknowledge message
	task automatic pulse(input int k);
		@(posedge clk);
		{send_req, resend_req, ack_rx_valid} <= 3'(3'h1 << k);
		@(posedge clk);
		{send_req, resend_req, ack_rx_valid} <= 3'h0;
	endtask : pulse

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_defaults;
		req(0, SVC_GET_SINGLE, ATTR_WAIT_TIME, 0, 0, 0, 16'h0010, 1);
		req(0, SVC_GET_SINGLE, ATTR_RETRY_LIMIT, 0, 0, 0, 16'h0001, 1);
		req(1, SVC_GET_SINGLE, CLS_ATTR_REVISION, 0, 0, 0, 16'h0001, 1);
		req(0, SVC_GET_SINGLE, ATTR_ACK_LIST_CAP, 0, 0, 0, 16'h0004, 1);
		req(0, SVC_GET_SINGLE, 8'h07, 0, 0, ST_ATTR_UNSUPPORTED, 0, 0);
		req(0, SVC_SET_SINGLE, ATTR_DPATH_CAP, 0, 1, ST_NOT_SETTABLE, 0, 0);
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_wait_time;
		req(0, SVC_SET_SINGLE, ATTR_WAIT_TIME, 0, 0, ST_INVALID_VALUE, 0, 0);
		req(0, SVC_GET_SINGLE, ATTR_WAIT_TIME, 0, 0, 0, 16'h0010, 1);
		req(0, SVC_SET_SINGLE, ATTR_WAIT_TIME, 0, 21, 0, 16'h0018, 1);
		req(0, SVC_GET_SINGLE, ATTR_WAIT_TIME, 0, 0, 0, 16'h0018, 1);
		$display("test wait time done");
	endtask : t_wait_time

	task automatic t_list;
		conn(16'h0005, 2'h2);
		chk(active, 1'b1);
		req(0, SVC_SET_SINGLE, ATTR_PROD_REF, 0, 9, ST_STATE_CONFLICT, 0, 0);
		req(0, SVC_GET_SINGLE, ATTR_ACK_LIST, 0, 0, 0, 16'h0001, 1);
		req(0, SVC_GET_SINGLE, ATTR_ACK_LIST, 1, 0, 0, 16'h0005, 1);
		req(0, SVC_GET_SINGLE, ATTR_ACK_LIST, 2, 0, ST_INVALID_VALUE, 0, 0);
		$display("test list done");
	endtask : t_list

	task automatic t_ack;
		req(0, SVC_ADD_DPATH, 0, 3, 16'h0005, 0, 0, 0);
		req(0, SVC_ADD_DPATH, 0, 2, 16'h0007, ST_STATE_CONFLICT, 0, 0);
		pulse(2);
		repeat (5) @(posedge clk);
		{ack_rx_id, ack_rx_has_data} <= {16'h0005, 1'b1};
		pulse(0);
		#1;
		chk(ack_received_evt, 1'b1);
		chk(fwd, 1'b1);
		chk(fwd_len, 8'h03);
		$display("test ack done");
	endtask : t_ack

	// wait 24 ms of 10-cycle ticks, limit 2, resend by the producer
	task automatic t_timeout;
		req(0, SVC_SET_SINGLE, ATTR_RETRY_LIMIT, 0, 2, 0, 0, 0);
		pulse(2);
		wait_to();
		chk(16'(n >= 24 * TCK && n <= 26 * TCK), 16'h1);
		chk(exh, 1'b0);
		@(posedge clk);
		#1;
		wait_to();
		chk(exh, 1'b1);
		req(0, SVC_SET_SINGLE, ATTR_RETRY_LIMIT, 0, 2, 0, 0, 0);
		pulse(1);
		wait_to();
		chk(exh, 1'b0);
		$display("test timeout done");
	endtask : t_timeout

	task automatic t_remove;
		conn(16'h0005, 2'h0);
		chk(active, 1'b0);
		req(0, SVC_SET_SINGLE, ATTR_PROD_REF, 0, 16'h0042, 0, 0, 0);
		chk(notify_conn_ref, 16'h0042);
		req(0, SVC_REMOVE_DPATH, 0, 0, 16'h0009, ST_INVALID_VALUE, 0, 0);
		req(0, SVC_REMOVE_DPATH, 0, 0, 16'h0005, 0, 0, 0);
		req(0, SVC_REMOVE_DPATH, 0, 0, 16'h0005, ST_INVALID_VALUE, 0, 0);
		$display("test remove done");
	endtask : t_remove

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		t_defaults();
		t_wait_time();
		t_list();
		t_ack();
		t_timeout();
		t_remove();
		final_report();
	end

endmodule : ahrt_ack_handler_tb

`default_nettype wire
